// *** hw/fbp_params.svh ***
// constants for the fetch and branch predictor block
`ifndef FBP_PARAMS_SVH
`define FBP_PARAMS_SVH

// ----------------------------------------
// table sizes
// ----------------------------------------
`define FBP_BTC_ENTRIES 64
`define FBP_BHT_ENTRIES 512

// ----------------------------------------
// history counter states
// ----------------------------------------
`define FBP_BHT_STRONG_T 2'h3
`define FBP_BHT_WEAK_T 2'h2
`define FBP_BHT_WEAK_N 2'h1
`define FBP_BHT_STRONG_N 2'h0
`define FBP_BHT_RESET 2'h1

// ----------------------------------------
// fetch geometry and reset values
// ----------------------------------------
`define FBP_BLK_WORDS 4'h8
`define FBP_GRP_MAX 3'h4
`define FBP_PAIR 3'h2
`define FBP_BEATS_LAST 2'h3
`define FBP_RST_PC 32'h0000_0000

`endif

// *** hw/fbp_pkg.sv ***
// types shared by the fetch and branch predictor block
package fbp_pkg;

  // ----------------------------------------
  // branch classes seen in decode
  // ----------------------------------------
  typedef enum logic [1:0] {
    fbp_br_none,
    fbp_br_uncond,
    fbp_br_ctr,
    fbp_br_cr
  } fbp_br_kind_t;

  // line fill sequencer states
  typedef enum logic [1:0] {
    fbp_fill_idle,
    fbp_fill_arb,
    fbp_fill_beat
  } fbp_fill_st_t;

  // first branch of a decoded group
  typedef struct packed {
    logic valid;
    fbp_br_kind_t kind;
    logic [31:0] pc;
    logic [31:0] target;
    logic prior_taken;
    logic ctr_on_zero;
  } fbp_dec_t;

  // executed branch outcome
  typedef struct packed {
    logic valid;
    logic is_cr;
    logic [31:0] pc;
    logic [31:0] grp_pc;
    logic [31:0] target;
    logic taken;
  } fbp_res_t;

  // instruction cache write port
  typedef struct packed {
    logic en;
    logic [31:3] addr;
    logic [63:0] data;
  } fbp_cw_t;

endpackage

// *** hw/fbp_fetch_branch_predictor.sv ***
// fetch front end: target cache, history table, line fill
//
// Contract
// - 64-entry fully associative branch target cache
// - store only predicted-taken branch targets
// - search target cache with fetch address
// - on hit fetch target next cycle
// - on miss advance by instructions placed
// - predict first branch of decoded group
// - unconditional not-taken earlier: redirect to target
// - count branch: predict from count, redirect differences
// - condition-bit branch predicted by history table
// - history table 512 direct-mapped 2-bit entries
// - four states, two taken states predict taken
// - update entry on each executed condition branch
// - update moves one step toward outcome
// - cache miss starts whole-line fill
// - critical double word written and forwarded immediately
// - remaining double words forwarded as they arrive; code forwards only a beat holding the current fetch pair
// - hits to other lines served during fill
// - second miss waits for current fill
// - four-beat burst, critical double word first
// - each beat gives one pair; fetch only delivered
// - cache hit reaches queue one cycle later
// - pairs from one block, four max, block end
`timescale 1ns/1ps
`include "fbp_params.svh"

module fbp_fetch_branch_predictor #(
  parameter int BTC_N = `FBP_BTC_ENTRIES,
  parameter int BHT_N = `FBP_BHT_ENTRIES
) (
  input wire logic clk,
  input wire logic rstn,
  output logic [31:0] fetch_addr,
  input wire logic ic_hit,
  input wire logic [127:0] ic_rd_data,
  input wire logic [2:0] iq_room,
  output logic iq_valid,
  output logic [2:0] iq_count,
  output logic [127:0] iq_instr,
  output logic fill_req,
  output logic [31:3] fill_addr,
  input wire logic fill_ack,
  input wire logic beat_valid,
  input wire logic [63:0] beat_data,
  output fbp_pkg::fbp_cw_t cache_wr,
  input wire fbp_pkg::fbp_dec_t dec_br,
  input wire logic [31:0] count_register,
  output logic pred_valid,
  output logic pred_taken,
  output logic redirect,
  input wire fbp_pkg::fbp_res_t res_br
);

  localparam int BW = $clog2(BTC_N);
  localparam int HW = $clog2(BHT_N);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] pc_ff; // current fetch address
  logic btc_vld_ff [BTC_N]; // entry valid
  logic [29:0] btc_tag_ff [BTC_N]; // group word address
  logic [31:0] btc_tgt_ff [BTC_N]; // predicted target
  logic [BW-1:0] rr_ff; // round robin victim
  logic [1:0] bht_ff [BHT_N]; // 2-bit counters
  fbp_pkg::fbp_fill_st_t st_ff; // fill sequencer
  logic [1:0] beat_cnt_ff; // beats taken so far
  logic [31:3] fill_addr_ff; // critical double word
  fbp_pkg::fbp_cw_t cw_ff; // cache write
  logic iq_valid_ff;
  logic [2:0] iq_count_ff;
  logic [127:0] iq_instr_ff;
  logic pred_valid_ff;
  logic pred_taken_ff;
  logic redir_ff;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // associative search, first match wins
  // any entry may match
  function automatic logic [BW:0] btc_find(input logic [29:0] key);
    logic [BW:0] r;
    r = '0;
    for (int i = 0; i < BTC_N; i++) begin
      if (!r[BW] && btc_vld_ff[i] && btc_tag_ff[i] == key) begin
        r = {1'b1, BW'(i)};
      end
    end
    return r;
  endfunction

  // smaller of two counts
  function automatic logic [2:0] min3(input logic [2:0] a, input logic [2:0] b);
    return (a < b) ? a : b;
  endfunction

  // ----------------------------------------
  // fetch stage
  // ----------------------------------------
  // lookup keyed by fetch address
  wire [BW:0] f_find = btc_find(pc_ff[31:2]);
  wire f_btc_hit = f_find[BW];
  wire [31:0] f_btc_tgt = btc_tgt_ff[f_find[BW-1:0]];

  // words left in block, capped at four
  wire [3:0] blk_left = `FBP_BLK_WORDS - {1'b0, pc_ff[4:2]};
  wire [2:0] grp_avail = (blk_left > 4'(`FBP_GRP_MAX)) ? `FBP_GRP_MAX : blk_left[2:0];
  // queue space in whole pairs only
  wire [2:0] room_pairs = {iq_room[2:1], 1'b0};

  // a beat carrying the fetch pair
  wire beat_match = (st_ff == fbp_pkg::fbp_fill_beat) && beat_valid
                    && ({fill_addr_ff[31:5], fill_addr_ff[4:3] + beat_cnt_ff} == pc_ff[31:3]);
  // odd start inside the beat leaves one word
  wire [2:0] beat_avail = pc_ff[2] ? 3'h1 : `FBP_PAIR;

  // hits are served in any fill state
  wire [2:0] placed = beat_match ? min3(beat_avail, room_pairs)
                    : ic_hit ? min3(grp_avail, room_pairs) : 3'h0;
  wire took = placed != 3'h0;

  // ----------------------------------------
  // decode correction
  // ----------------------------------------
  wire [HW-1:0] d_idx = dec_br.pc[HW+1:2];
  wire [31:0] ctr_dec = count_register - 32'h1;
  wire ctr_pred = (ctr_dec == 32'h0) == dec_br.ctr_on_zero;
  // taken states carry the high bit
  wire cr_pred = bht_ff[d_idx][1];
  logic d_pred;
  always_comb begin
    unique case (dec_br.kind)
      fbp_pkg::fbp_br_uncond: d_pred = 1'b1;
      fbp_pkg::fbp_br_ctr: d_pred = ctr_pred;
      fbp_pkg::fbp_br_cr: d_pred = cr_pred;
      fbp_pkg::fbp_br_none: d_pred = dec_br.prior_taken;
    endcase
  end
  wire d_active = dec_br.valid && dec_br.kind != fbp_pkg::fbp_br_none;
  wire d_redir = d_active && (d_pred != dec_br.prior_taken);
  wire [31:0] d_tgt = d_pred ? dec_br.target : dec_br.pc + 32'h4;

  // ----------------------------------------
  // next fetch address
  // ----------------------------------------
  // decode correction beats any fetch-stage guess
  logic [31:0] nxt_pc;
  always_comb begin
    if (d_redir) begin
      nxt_pc = d_tgt;
    end else if (took && f_btc_hit) begin
      nxt_pc = f_btc_tgt;
    end else if (took) begin
      nxt_pc = pc_ff + {27'h0, placed, 2'h0};
    end else begin
      // stall on miss or when queue room is under a pair
      nxt_pc = pc_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_ff <= `FBP_RST_PC;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // ----------------------------------------
  // instruction queue output
  // ----------------------------------------
  // registered, one cycle after request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      iq_valid_ff <= 1'b0;
      iq_count_ff <= 3'h0;
      iq_instr_ff <= 128'h0;
    end else begin
      iq_valid_ff <= took && !d_redir;
      iq_count_ff <= d_redir ? 3'h0 : placed;
      iq_instr_ff <= beat_match
                     ? {64'h0, pc_ff[2] ? {32'h0, beat_data[63:32]} : beat_data}
                     : ic_rd_data;
    end
  end

  // ----------------------------------------
  // line fill sequencer
  // ----------------------------------------
  // redirected fetches never start a fill
  wire miss = !ic_hit && !d_redir && !beat_match;
  wire last_beat = beat_valid && beat_cnt_ff == `FBP_BEATS_LAST;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= fbp_pkg::fbp_fill_idle;
      fill_addr_ff <= 29'h0;
      beat_cnt_ff <= 2'h0;
    end else begin
      unique case (st_ff)
        fbp_pkg::fbp_fill_idle: begin
          if (miss) begin
            st_ff <= fbp_pkg::fbp_fill_arb;
            fill_addr_ff <= pc_ff[31:3];
          end
        end
        // hold request until granted
        fbp_pkg::fbp_fill_arb: begin
          if (fill_ack) begin
            st_ff <= fbp_pkg::fbp_fill_beat;
            beat_cnt_ff <= 2'h0;
          end
        end
        fbp_pkg::fbp_fill_beat: begin
          if (beat_valid) begin
            beat_cnt_ff <= beat_cnt_ff + 2'h1;
          end
          if (last_beat) begin
            st_ff <= fbp_pkg::fbp_fill_idle;
          end
        end
        default: st_ff <= fbp_pkg::fbp_fill_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cw_ff <= '0;
    end else begin
      cw_ff.en <= (st_ff == fbp_pkg::fbp_fill_beat) && beat_valid;
      cw_ff.addr <= {fill_addr_ff[31:5], fill_addr_ff[4:3] + beat_cnt_ff};
      cw_ff.data <= beat_data;
    end
  end

  // ----------------------------------------
  // target cache maintenance
  // ----------------------------------------
  wire [BW:0] r_find = btc_find(res_br.grp_pc[31:2]);
  wire [BW-1:0] r_slot = r_find[BW] ? r_find[BW-1:0] : rr_ff;
  wire r_alloc = res_br.valid && res_br.taken;
  wire r_evict = res_br.valid && !res_br.taken && r_find[BW];

  // entries other than the slot stay untouched
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rr_ff <= '0;
      for (int i = 0; i < BTC_N; i++) begin
        btc_vld_ff[i] <= 1'b0;
        btc_tag_ff[i] <= 30'h0;
        btc_tgt_ff[i] <= 32'h0;
      end
    end else if (r_alloc) begin
      btc_vld_ff[r_slot] <= 1'b1;
      btc_tag_ff[r_slot] <= res_br.grp_pc[31:2];
      btc_tgt_ff[r_slot] <= res_br.target;
      // victim moves only on a fresh entry
      if (!r_find[BW]) begin
        rr_ff <= rr_ff + BW'(1);
      end
    end else if (r_evict) begin
      btc_vld_ff[r_slot] <= 1'b0;
    end
  end

  // ----------------------------------------
  // history table
  // ----------------------------------------
  // low word-address bits of branch
  wire [HW-1:0] r_idx = res_br.pc[HW+1:2];
  wire [1:0] r_old = bht_ff[r_idx];
  wire [1:0] r_new = res_br.taken
                     ? ((r_old == `FBP_BHT_STRONG_T) ? r_old : r_old + 2'h1)
                     : ((r_old == `FBP_BHT_STRONG_N) ? r_old : r_old - 2'h1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < BHT_N; i++) begin
        bht_ff[i] <= `FBP_BHT_RESET;
      end
    end else if (res_br.valid && res_br.is_cr) begin
      bht_ff[r_idx] <= r_new;
    end
  end

  // ----------------------------------------
  // prediction report
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pred_valid_ff <= 1'b0;
      pred_taken_ff <= 1'b0;
      redir_ff <= 1'b0;
    end else begin
      pred_valid_ff <= d_active;
      pred_taken_ff <= d_pred;
      redir_ff <= d_redir;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign fetch_addr = pc_ff;
  assign iq_valid = iq_valid_ff;
  assign iq_count = iq_count_ff;
  assign iq_instr = iq_instr_ff;
  assign fill_req = st_ff == fbp_pkg::fbp_fill_arb;
  assign fill_addr = fill_addr_ff;
  assign cache_wr = cw_ff;
  assign pred_valid = pred_valid_ff;
  assign pred_taken = pred_taken_ff;
  assign redirect = redir_ff;

endmodule

// *** tb/fbp_fetch_chk_sva.sv ***
// port checker for the fetch and branch predictor
`timescale 1ns/1ps
module fbp_fetch_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] fetch_addr,
  input wire logic ic_hit,
  input wire logic [2:0] iq_room,
  input wire logic iq_valid,
  input wire logic [2:0] iq_count,
  input wire logic fill_req,
  input wire logic [31:3] fill_addr,
  input wire logic fill_ack,
  input wire logic beat_valid,
  input wire logic [63:0] beat_data,
  input wire fbp_pkg::fbp_cw_t cache_wr,
  input wire fbp_pkg::fbp_dec_t dec_br,
  input wire logic [31:0] count_register,
  input wire logic pred_valid,
  input wire logic pred_taken,
  input wire logic redirect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // plain hit cycle, nothing from decode or the bus in play
  wire quiet = ic_hit && iq_room == 3'h4 && !dec_br.valid && !beat_valid;
  wire is_unc = dec_br.valid && dec_br.kind == fbp_pkg::fbp_br_uncond;
  wire is_ctr = dec_br.valid && dec_br.kind == fbp_pkg::fbp_br_ctr;
  sequence s_wait_ack;
    fill_req && !fill_ack;
  endsequence
  sequence s_beat;
    beat_valid;
  endsequence
  a_req_held: assert property (s_wait_ack |=> fill_req && $stable(fill_addr))
    else $error("fill request dropped before grant");
  a_req_drop: assert property (fill_ack |=> !fill_req)
    else $error("fill request kept after grant");
  a_beat_write: assert property (s_beat |=> cache_wr.en && cache_wr.data == $past(beat_data))
    else $error("beat not written to cache");
  a_write_cause: assert property (cache_wr.en |-> $past(beat_valid))
    else $error("cache write without a beat");
  a_hit_full: assert property (quiet && fetch_addr[4:2] == 3'h0 |=> iq_valid && iq_count == 3'h4)
    else $error("aligned hit did not place four");
  a_blk_end: assert property (quiet && fetch_addr[4:2] == 3'h6 |=> iq_valid && iq_count == 3'h2)
    else $error("block end did not place two");
  a_no_room: assert property (iq_room < 3'h2 && !dec_br.valid && !beat_valid
    |=> !iq_valid && $stable(fetch_addr))
    else $error("placed without room");
  a_uncond_redir: assert property (is_unc && !dec_br.prior_taken
    |=> redirect && pred_taken && fetch_addr == $past(dec_br.target))
    else $error("unconditional branch not redirected");
  a_pred_lat: assert property (dec_br.valid && dec_br.kind != fbp_pkg::fbp_br_none |=> pred_valid)
    else $error("no prediction for decoded branch");
  a_ctr_pred: assert property (is_ctr |=> pred_taken ==
    ((($past(count_register) - 32'h1) == 32'h0) == $past(dec_br.ctr_on_zero)))
    else $error("count branch mispredicted");
endmodule

bind fbp_fetch_branch_predictor fbp_fetch_chk fbp_fetch_chk_i (.clk, .rstn, .fetch_addr, .ic_hit, .iq_room,
  .iq_valid, .iq_count, .fill_req, .fill_addr, .fill_ack, .beat_valid, .beat_data, .cache_wr, .dec_br,
  .count_register, .pred_valid, .pred_taken, .redirect);

// *** tb/fbp_mem_model.sv ***
// cache and bus side model: hit answer and four-beat fill
`timescale 1ns/1ps
module fbp_mem_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] fetch_addr,
  input wire logic fill_req,
  input wire logic [31:3] fill_addr,
  output logic ic_hit,
  output logic [127:0] ic_rd_data,
  output logic fill_ack,
  output logic beat_valid,
  output logic [63:0] beat_data
);
  logic [3:0] ph_ff; // fill phase, zero when idle
  logic [31:3] crit_ff; // granted critical double word
  wire [2:0] beat_k = ph_ff[3:1] - 3'h1;
  wire [31:0] dw = {crit_ff[31:5], crit_ff[4:3] + beat_k[1:0], 3'h0};
  wire beat_now = !ph_ff[0] && ph_ff != 4'h0;
  // only the low 4 KB is resident; a word reads back as its address
  assign ic_hit = fetch_addr < 32'h0000_1000;
  assign ic_rd_data = ic_hit ? {fetch_addr + 32'hC, fetch_addr + 32'h8, fetch_addr + 32'h4, fetch_addr}
    : {4{~fetch_addr}};
  // critical dword first
  // beats every other cycle; data lines toggle between beats
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_ff <= 4'h0;
      crit_ff <= '0;
      fill_ack <= 1'b0;
      beat_valid <= 1'b0;
      beat_data <= '0;
    end else begin
      fill_ack <= ph_ff == 4'h0 && fill_req;
      beat_valid <= beat_now;
      beat_data <= beat_now ? {dw + 32'h4, dw} : ~beat_data;
      if (ph_ff == 4'h0 && fill_req) begin
        ph_ff <= 4'h1;
        crit_ff <= fill_addr;
      end else if (ph_ff != 4'h0) begin
        ph_ff <= (ph_ff == 4'h8) ? 4'h0 : ph_ff + 4'h1;
      end
    end
  end
endmodule

// *** tb/fbp_fetch_branch_predictor_test.sv ***
// self-checking bench for the fetch and branch predictor
`timescale 1ns/1ps
module fbp_fetch_branch_predictor_test;
  logic clk = 1'b0;
  logic rstn;
  logic [2:0] iq_room;
  fbp_pkg::fbp_dec_t dec_br;
  logic [31:0] count_register;
  fbp_pkg::fbp_res_t res_br;
  logic [31:0] fetch_addr;
  logic ic_hit, iq_valid, fill_req, fill_ack, beat_valid, pred_valid, pred_taken, redirect;
  logic [127:0] ic_rd_data, iq_instr;
  logic [2:0] iq_count;
  logic [31:3] fill_addr;
  logic [63:0] beat_data;
  fbp_pkg::fbp_cw_t cache_wr;
  int err_count, n_compared, nw, ni, nr;
  always #2.5 clk = ~clk;
  fbp_fetch_branch_predictor fbp_fetch_branch_predictor_i (.clk, .rstn, .fetch_addr, .ic_hit, .ic_rd_data,
    .iq_room, .iq_valid, .iq_count, .iq_instr, .fill_req, .fill_addr, .fill_ack, .beat_valid, .beat_data,
    .cache_wr, .dec_br, .count_register, .pred_valid, .pred_taken, .redirect, .res_br);
  fbp_mem_model fbp_mem_model_i (.clk, .rstn, .fetch_addr, .fill_req, .fill_addr, .ic_hit, .ic_rd_data,
    .fill_ack, .beat_valid, .beat_data);
  task automatic print_verdict;
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic ck(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      $display("Error %0t: %s", $time, m);
      err_count++;
    end
  endtask
  // one decode cycle, checked just after the sampling edge
  task automatic dec(input fbp_pkg::fbp_br_kind_t k, input logic [31:0] pc, t, input logic pr, cz);
    @(posedge clk) dec_br <= '{1'b1, k, pc, t, pr, cz};
    @(posedge clk) dec_br <= '0;
    #1;
  endtask
  task automatic rb(input logic tk);
    @(posedge clk) res_br <= '{1'b1, 1'b1, 32'h40, 32'h40, 32'h100, tk};
    @(posedge clk) res_br <= '0;
  endtask
  task automatic db;
    dec(fbp_pkg::fbp_br_cr, 32'h40, 32'h100, 1'b0, 1'b0);
  endtask
  task automatic t_uncond;
    dec(fbp_pkg::fbp_br_uncond, 32'h4, 32'h18, 1'b0, 1'b0);
    ck(fetch_addr === 32'h18 && redirect === 1'b1, "uncond redirect");
    @(posedge clk) #1;
    ck(iq_count === 3'h2 && iq_instr[63:0] === 64'h0000_001C_0000_0018, "block end");
    @(posedge clk) #1;
    ck(iq_valid === 1'b1 && iq_count === 3'h4 && fetch_addr === 32'h30, "sequential");
  endtask
  task automatic t_ctr;
    @(posedge clk) count_register <= 32'h1;
    dec(fbp_pkg::fbp_br_ctr, 32'h4, 32'h80, 1'b0, 1'b1);
    ck(pred_taken === 1'b1 && redirect === 1'b1 && fetch_addr === 32'h80, "count taken");
    @(posedge clk) count_register <= 32'h5;
    dec(fbp_pkg::fbp_br_ctr, 32'h4, 32'h80, 1'b0, 1'b1);
    ck(pred_valid === 1'b1 && pred_taken === 1'b0 && redirect === 1'b0, "count agrees");
  endtask
  task automatic t_bht;
    db;
    ck(pred_taken === 1'b0 && redirect === 1'b0, "history reset");
    rb(1'b1);
    rb(1'b1);
    db;
    ck(pred_taken === 1'b1 && fetch_addr === 32'h100, "history taken");
    dec(fbp_pkg::fbp_br_cr, 32'h840, 32'h100, 1'b1, 1'b0);
    ck(pred_taken === 1'b1 && redirect === 1'b0, "history alias");
    rb(1'b0);
    db;
    ck(pred_taken === 1'b1, "one step down");
    rb(1'b0);
    db;
    ck(pred_taken === 1'b0, "weak not taken");
  endtask
  task automatic t_btc;
    @(posedge clk) res_br <= '{1'b1, 1'b0, 32'h20C, 32'h200, 32'h300, 1'b1};
    @(posedge clk) res_br <= '0;
    dec(fbp_pkg::fbp_br_uncond, 32'h4, 32'h200, 1'b0, 1'b0);
    @(posedge clk) #1;
    ck(fetch_addr === 32'h300, "target hit");
    @(posedge clk) res_br <= '{1'b1, 1'b0, 32'h20C, 32'h200, 32'h300, 1'b0};
    @(posedge clk) res_br <= '0;
    dec(fbp_pkg::fbp_br_uncond, 32'h4, 32'h200, 1'b0, 1'b0);
    @(posedge clk) #1;
    ck(fetch_addr === 32'h210, "evicted entry");
  endtask
  task automatic t_room;
    @(posedge clk) iq_room <= 3'h1;
    repeat (3) @(posedge clk);
    #1;
    ck(iq_valid === 1'b0, "no room");
    @(posedge clk) iq_room <= 3'h4;
  endtask
  task automatic t_miss;
    nw = 0;
    ni = 0;
    nr = 0;
    dec(fbp_pkg::fbp_br_uncond, 32'h4, 32'h1008, 1'b0, 1'b0);
    for (int i = 0; i < 300 && nw < 4; i++) begin
      @(posedge clk) #1;
      if (iq_valid === 1'b1 && ni == 0) ck(iq_instr[63:0] === 64'h0000_100C_0000_1008, "critical");
      ni += int'(iq_valid === 1'b1 && iq_count === 3'h2);
      nr += int'(fill_req === 1'b1 && nw > 0);
      if (cache_wr.en === 1'b1) ck(cache_wr.addr === 29'h0000_0200 + 29'((nw + 1) % 4), "write order");
      nw += int'(cache_wr.en === 1'b1);
    end
    ck(nw == 4 && ni == 3 && nr == 0, "fill beats");
    if (nw < 4) print_verdict;
    for (int i = 0; i < 20 && fill_req !== 1'b1; i++) @(posedge clk) #1;
    ck(fill_req === 1'b1 && fill_addr === 29'h0000_0204, "second fill");
    dec(fbp_pkg::fbp_br_uncond, 32'h4, 32'h400, 1'b0, 1'b0);
    @(posedge clk) #1;
    ck(iq_valid === 1'b1 && iq_count === 3'h4, "hit during fill");
  endtask
  initial begin
    rstn = 1'b0;
    iq_room = 3'h4;
    dec_br = '0;
    count_register = '0;
    res_br = '0;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_uncond;
    t_ctr;
    t_bht;
    t_btc;
    t_room;
    t_miss;
    print_verdict;
  end
endmodule
